// ---- logic/pdhp_host_port.sv ----
// Strobe-driven host port of a palette DAC, sampled on the system clock
`timescale 1ns/10ps
// Behaviour
// - Write data taken at write strobe rising
// - Write select taken at write strobe falling
// - Drive data only while read strobe low
// - Read select taken at read strobe falling
// - Select code chooses the access kind
module pdhp_host_port #(
  // Host bus widths; the carriers in the package fix them
  parameter int DATA_W = pdhp_pkg::PDHP_DATA_W,
  parameter int SEL_W = pdhp_pkg::PDHP_SEL_W,
  parameter int COLOUR_W = pdhp_pkg::PDHP_NARROW_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Host pins
  input wire pdhp_pkg::pdhp_pins_t pins,
  input wire logic width_sel_8,
  output logic [7:0] host_data_bus_o,
  output logic host_data_oe_n,
  // Core side
  output pdhp_pkg::pdhp_wr_t wr_evt,
  output pdhp_pkg::pdhp_rd_t rd_req,
  input wire logic [7:0] rd_data
);
  import pdhp_pkg::*;

  // The carriers in the package fix every width, so refuse any other value
  if (DATA_W != PDHP_DATA_W || SEL_W != PDHP_SEL_W ||
      COLOUR_W != PDHP_NARROW_W) begin : g_bad_width
    $error("pdhp_host_port: widths must match the package carriers");
  end

  // Latency: every pin passes two flip-flops and one output register, so an
  // event surfaces three clocks after the pin moves. Hosts must hold each
  // strobe level, and the select around the asserting edge, for at least
  // one clock, or the edge is missed. The bus enable also trails the
  // read strobe by three clocks after release; the host must allow for it.
  //
  // Write walk: strobe low at c0, select held at c3, strobe high at cN,
  // one-clock event with select and data at cN+3.
  // Read walk: strobe low at c0, request and bus enable at c3, read data
  // on the bus from c4, enable dropped three clocks after the strobe rises.

  // Synchroniser stages for all host pins
  pdhp_pins_t sync1_q, sync1_d; // First stage, may be metastable
  pdhp_pins_t sync2_q, sync2_d; // Second stage, safe to read
  logic wide1_q, wide1_d; // Width pin, first stage
  logic wide2_q, wide2_d; // Width pin, second stage
  // Previous strobe levels for edge detection
  logic rd_n_prev_q, rd_n_prev_d; // Read strobe one clock ago
  logic wr_n_prev_q, wr_n_prev_d; // Write strobe one clock ago
  // Write capture state
  logic [2:0] wr_sel_q, wr_sel_d; // Select taken at write start
  pdhp_wr_t wr_q, wr_d; // Write event towards the core
  // Read capture state
  pdhp_rd_t rd_q, rd_d; // Read request towards the core
  logic [2:0] rd_sel_now; // Select of the read under way
  // Bus drive state
  logic [7:0] dout_q, dout_d; // Data driven onto the host bus
  logic oe_n_q, oe_n_d; // Bus enable, low while driving
  // Decoded strobe edges and qualifiers
  logic wr_fall; // Write strobe just asserted
  logic wr_rise; // Write strobe just released
  logic rd_fall; // Read strobe just asserted
  logic rd_active; // Read strobe low, write strobe high
  logic wr_colour; // Write targets a colour register
  logic rd_colour; // Read targets a colour register

  // Synchroniser next values
  always_comb begin
    sync1_d = pins;
    sync2_d = sync1_q; // Only the second stage reads the first
    wide1_d = width_sel_8;
    wide2_d = wide1_q;
  end

  // Synchroniser registers
  always_ff @(posedge clock) begin
    if (rst) begin
      // Strobes idle high so no false edge follows reset
      sync1_q <= '{rd_n: 1'b1, wr_n: 1'b1, register_select_code: PDHP_SEL_RST,
                   host_data_bus: PDHP_DATA_RST};
      sync2_q <= '{rd_n: 1'b1, wr_n: 1'b1, register_select_code: PDHP_SEL_RST,
                   host_data_bus: PDHP_DATA_RST};
      wide1_q <= 1'b1;
      wide2_q <= 1'b1;
    end else begin
      // Advance the pin samples
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      wide1_q <= wide1_d;
      wide2_q <= wide2_d;
    end
  end

  // Strobe history next values
  always_comb begin
    rd_n_prev_d = sync2_q.rd_n;
    wr_n_prev_d = sync2_q.wr_n;
  end

  // Strobe history registers
  always_ff @(posedge clock) begin
    if (rst) begin
      // Idle high, matching the released strobes
      rd_n_prev_q <= 1'b1;
      wr_n_prev_q <= 1'b1;
    end else begin
      // Remember last synchronised levels
      rd_n_prev_q <= rd_n_prev_d;
      wr_n_prev_q <= wr_n_prev_d;
    end
  end

  // Strobe edges and colour decode on synchronised levels
  always_comb begin
    wr_fall = wr_n_prev_q && !sync2_q.wr_n;
    wr_rise = !wr_n_prev_q && sync2_q.wr_n;
    rd_fall = rd_n_prev_q && !sync2_q.rd_n;
    // Overlapped strobes give no access
    rd_active = !sync2_q.rd_n && sync2_q.wr_n;
    // Fresh select on the read's first clock, else the held one
    rd_sel_now = rd_q.sel;
    if (rd_fall) begin
      rd_sel_now = sync2_q.register_select_code;
    end
    wr_colour = (wr_sel_q == PDHP_SEL_PAL_DATA) || (wr_sel_q == PDHP_SEL_OVL_DATA);
    rd_colour = (rd_sel_now == PDHP_SEL_PAL_DATA) || (rd_sel_now == PDHP_SEL_OVL_DATA);
  end

  // Write capture next values
  always_comb begin
    wr_sel_d = wr_sel_q;
    wr_d = '{valid: 1'b0, sel: wr_q.sel, data: wr_q.data};
    // Select caught at write start
    if (wr_fall) begin
      wr_sel_d = sync2_q.register_select_code;
    end
    // Data caught at write end; a low read strobe refuses it
    if (wr_rise && sync2_q.rd_n) begin
      wr_d.valid = 1'b1;
      wr_d.sel = wr_sel_q;
      wr_d.data = sync2_q.host_data_bus;
      // Narrow colour writes drop upper bits
      if (!wide2_q && wr_colour) begin
        wr_d.data = sync2_q.host_data_bus & PDHP_NARROW_MASK;
      end
    end
  end

  // Write capture registers
  always_ff @(posedge clock) begin
    if (rst) begin
      // No write pending
      wr_sel_q <= PDHP_SEL_RST;
      wr_q <= '{valid: 1'b0, sel: PDHP_SEL_RST, data: PDHP_DATA_RST};
    end else begin
      wr_sel_q <= wr_sel_d;
      wr_q <= wr_d;
    end
  end

  // Read capture next values
  always_comb begin
    rd_d = '{valid: 1'b0, sel: rd_q.sel};
    // Select caught at read start, request raised once
    if (rd_fall && sync2_q.wr_n) begin
      rd_d.valid = 1'b1;
      rd_d.sel = sync2_q.register_select_code;
    end
  end

  // Read capture registers
  always_ff @(posedge clock) begin
    if (rst) begin
      // No read pending
      rd_q <= '{valid: 1'b0, sel: PDHP_SEL_RST};
    end else begin
      rd_q <= rd_d;
    end
  end

  // Bus drive next values
  always_comb begin
    dout_d = dout_q;
    oe_n_d = 1'b1;
    // Drive bus only while read strobe low
    if (rd_active) begin
      oe_n_d = 1'b0;
      dout_d = rd_data;
      // Narrow colour reads return zero in upper bits, first clock too
      if (!wide2_q && rd_colour) begin
        dout_d = rd_data & PDHP_NARROW_MASK;
      end
    end
  end

  // Bus drive registers
  always_ff @(posedge clock) begin
    if (rst) begin
      // Bus released, data cleared
      dout_q <= PDHP_DATA_RST;
      oe_n_q <= 1'b1;
    end else begin
      dout_q <= dout_d;
      oe_n_q <= oe_n_d;
    end
  end

  // Outputs straight from flip-flops
  assign host_data_bus_o = dout_q;
  assign host_data_oe_n = oe_n_q;
  assign wr_evt = wr_q;
  assign rd_req = rd_q;
endmodule

// ---- logic/pdhp_pkg.sv ----
// Package for the palette DAC host port: select codes, widths, structs
package pdhp_pkg;
  localparam int PDHP_DATA_W = 8;
  localparam int PDHP_SEL_W = 3;
  localparam int PDHP_NARROW_W = 6;
  localparam int PDHP_SYNC_STAGES = 2;
  localparam logic [7:0] PDHP_NARROW_MASK = 8'h3F;
  localparam logic [7:0] PDHP_DATA_RST = 8'h00;
  localparam logic [2:0] PDHP_SEL_RST = 3'h0;
  // Select codes: colour accesses are palette data and overlay data
  localparam logic [2:0] PDHP_SEL_PAL_DATA = 3'h1;
  localparam logic [2:0] PDHP_SEL_OVL_DATA = 3'h5;

  // Raw host pins
  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic [2:0] register_select_code;
    logic [7:0] host_data_bus;
  } pdhp_pins_t;

  // Write event delivered to the core
  typedef struct packed {
    logic valid;
    logic [2:0] sel;
    logic [7:0] data;
  } pdhp_wr_t;

  // Read request delivered to the core
  typedef struct packed {
    logic valid;
    logic [2:0] sel;
  } pdhp_rd_t;
endpackage

// ---- sim/pdhp_host.sv ----
// Host bus model for the palette DAC host port
`timescale 1ns/10ps
module pdhp_host import pdhp_pkg::*; (
  // Clock
  input wire logic clock,
  // Device bus side
  input wire logic host_data_oe_n,
  input wire logic [7:0] host_data_bus_o,
  // Host pins
  output pdhp_pins_t pins
);
  logic rd_n = 1'b1, wr_n = 1'b1;
  logic [2:0] s_q = 3'h0;
  logic [7:0] hd = 8'h00;
  // Device drives the bus only while its enable is low
  assign pins = {rd_n, wr_n, s_q, host_data_oe_n ? hd : host_data_bus_o};
  // One access; select moves after the fall
  task automatic acc(input logic w, input logic [2:0] s, s2, input logic [7:0] d,
    output logic [7:0] r);
    s_q <= s;
    hd <= d;
    repeat (4) @(posedge clock);
    if (w) wr_n <= 1'b0;
    else rd_n <= 1'b0;
    repeat (4) @(posedge clock);
    s_q <= s2;
    repeat (4) @(posedge clock);
    r = pins.host_data_bus;
    wr_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (4) @(posedge clock);
    hd <= ~d; // Released bus shows the inverse
    @(posedge clock);
  endtask
endmodule

// ---- sim/pdhp_host_port_monitor.sv ----
// Checker for the palette DAC host port
`timescale 1ns/10ps
module pdhp_host_port_monitor import pdhp_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Host side
  input wire pdhp_pins_t pins,
  input wire logic width_sel_8,
  input wire logic host_data_oe_n,
  input wire logic [7:0] host_data_bus_o,
  // Core side
  input wire logic [7:0] rd_data,
  input wire pdhp_wr_t wr_evt,
  input wire pdhp_rd_t rd_req
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [2:0] sel_q; // Select seen at strobe fall
  always_ff @(posedge clock) if ($fell(pins.wr_n) || $fell(pins.rd_n))
    sel_q <= pins.register_select_code;
  property p_wt; $rose(pins.wr_n) && pins.rd_n |-> ##[2:5] wr_evt.valid; endproperty
  a_wt: assert property (p_wt) else $error("wt");
  property p_ws; wr_evt.valid |-> wr_evt.sel == sel_q; endproperty
  a_ws: assert property (p_ws) else $error("ws");
  property p_rt; $fell(pins.rd_n) && pins.wr_n |-> ##[2:5] rd_req.valid; endproperty
  a_rt: assert property (p_rt) else $error("rt");
  property p_rs; rd_req.valid |-> rd_req.sel == sel_q; endproperty
  a_rs: assert property (p_rs) else $error("rs");
  property p_oe; pins.rd_n [*6] |-> host_data_oe_n; endproperty
  a_oe: assert property (p_oe) else $error("oe");
  property p_rd; !host_data_oe_n && $past(!host_data_oe_n) && width_sel_8
    |-> host_data_bus_o == $past(rd_data); endproperty
  a_rd: assert property (p_rd) else $error("rd");
  property p_nz; !host_data_oe_n && !width_sel_8 && (rd_req.sel == PDHP_SEL_PAL_DATA ||
    rd_req.sel == PDHP_SEL_OVL_DATA) |-> host_data_bus_o[7:6] == 2'h0; endproperty
  a_nz: assert property (p_nz) else $error("nz");
  cover property (!host_data_oe_n && !width_sel_8);
  cover property (wr_evt.valid);
  cover property (rd_req.valid);
  cover property (!host_data_oe_n);
endmodule
bind pdhp_host_port pdhp_host_port_monitor mon (.*);

// ---- sim/pdhp_host_port_tb.sv ----
// Bench for the palette DAC host port
`timescale 1ns/10ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin num_errors++; \
  $display("unexpected %s %h %h", n, e, s); end end
module pdhp_host_port_tb;
  import pdhp_pkg::*;
  logic clock = 1'b0, rst = 1'b1, width_sel_8 = 1'b1, host_data_oe_n;
  logic [7:0] rd_data = 8'hC9, host_data_bus_o, r;
  pdhp_pins_t pins;
  pdhp_wr_t wr_evt;
  pdhp_rd_t rd_req;
  int num_errors = 0, checks = 0, cyc = 0;
  pdhp_host h (.*);
  pdhp_host_port dut (.*);
  initial forever #20 clock = ~clock;
  task automatic stop_test();
    if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Cycle ceiling
  always @(posedge clock) begin
    cyc++;
    if (cyc == 400) num_errors++;
    if (cyc == 400) stop_test();
  end
  // Wide write then read, select moved mid-strobe
  task automatic t_wide();
    h.acc(1'b1, PDHP_SEL_PAL_DATA, 3'h6, 8'hA5, r);
    `CHK("wsel", PDHP_SEL_PAL_DATA, wr_evt.sel)
    `CHK("wdat", 8'hA5, wr_evt.data)
    h.acc(1'b0, PDHP_SEL_OVL_DATA, 3'h2, 8'h00, r);
    `CHK("rsel", PDHP_SEL_OVL_DATA, rd_req.sel)
    `CHK("rdat", 8'hC9, r)
  endtask
  // Six-bit mode: colour write and read, plus a non-colour read
  task automatic t_narrow();
    width_sel_8 <= 1'b0;
    h.acc(1'b1, PDHP_SEL_OVL_DATA, 3'h0, 8'hFF, r);
    `CHK("nwdat", 8'h3F, wr_evt.data)
    h.acc(1'b0, 3'h0, 3'h0, 8'h00, r);
    `CHK("nrraw", 8'hC9, r)
    h.acc(1'b0, PDHP_SEL_PAL_DATA, 3'h3, 8'h00, r);
    `CHK("nrdat", 8'h09, r)
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    t_wide();
    t_narrow();
    stop_test();
  end
endmodule
